// ===== src/tcf_pkg.sv
// constants, types and helpers for the transmit cell fifo addressing block
`default_nettype none
package tcf_pkg;

  // ==========================================================
  // register offsets on the processor port
  localparam logic [15:0] OFS_CS_BASE = 16'h2040;
  localparam logic [15:0] OFS_FIFO_CFG = 16'h2050;
  localparam logic [15:0] OFS_WR_INDEX = 16'h2052;
  localparam logic [15:0] OFS_RD_INDEX = 16'h2054;

  // ==========================================================
  // field layout
  localparam int CS_BASE_W = 5;
  localparam int FIFO_BASE_W = 12;
  localparam int SIZE_LSB = 12;
  localparam int SIZE_MSB = 13;
  localparam int WR_INDEX_W = 8;
  localparam int RD_INDEX_W = 7;
  localparam int ENTRY_W = 12;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;

  // ==========================================================
  // reset values
  localparam logic [4:0] RST_CS_BASE = 5'h00;
  localparam logic [11:0] RST_FIFO_BASE = 12'h000;
  localparam logic [1:0] RST_SIZE_CODE = 2'h0;
  localparam logic [7:0] RST_WR_INDEX = 8'h00;
  localparam logic [6:0] RST_RD_INDEX = 7'h00;

  // ==========================================================
  // size codes
  localparam logic [1:0] SIZE_16 = 2'h0;
  localparam logic [1:0] SIZE_32 = 2'h1;
  localparam logic [1:0] SIZE_64 = 2'h2;
  localparam logic [1:0] SIZE_128 = 2'h3;

  // ==========================================================
  // types
  typedef struct packed {
    logic [4:0] ctrl_struct_addr_high;
    logic [11:0] cell_fifo_base;
    logic [1:0] cell_fifo_size_code;
    logic [7:0] cell_fifo_wr_index;
  } tcf_cfg_t;

  typedef struct packed {
    logic cs;
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } tcf_cpu_req_t;

  typedef enum logic [1:0] {
    TCF_IDLE = 2'h0,
    TCF_SEND = 2'h1
  } tcf_state_t;

  // ==========================================================
  // helpers
  function automatic logic [6:0] tcf_size_mask(input logic [1:0] code);
    case (code)
      SIZE_16: tcf_size_mask = 7'h0F;
      SIZE_32: tcf_size_mask = 7'h1F;
      SIZE_64: tcf_size_mask = 7'h3F;
      default: tcf_size_mask = 7'h7F;
    endcase
  endfunction

  // 64-byte cell slots above a 512-byte aligned base
  function automatic logic [20:0] tcf_cell_addr(input logic [11:0] base,
                                                input logic [6:0] idx);
    tcf_cell_addr = {base, 9'h000} + {8'h00, idx, 6'h00};
  endfunction

endpackage
`default_nettype wire

// ===== src/tcf_regs.sv
// processor-port register file of the transmit cell fifo addressing block
`timescale 1ns/100ps
`default_nettype none
module tcf_regs (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // processor port
  input wire tcf_pkg::tcf_cpu_req_t cpu_req,
  output logic [15:0] cpu_rdata,
  // block state and configuration
  input wire logic [6:0] rd_index,
  output tcf_pkg::tcf_cfg_t cfg
);

  typedef struct packed {
    tcf_pkg::tcf_cfg_t cfg;
    logic [15:0] rdata;
  } tcf_regs_st_t;

  tcf_regs_st_t st;
  tcf_regs_st_t next_st;

  // ==========================================================
  // write and read decode
  always_comb
  begin
    next_st = st;
    if (cpu_req.cs && cpu_req.wr)
    begin
      case (cpu_req.addr)
        tcf_pkg::OFS_CS_BASE:
          next_st.cfg.ctrl_struct_addr_high = cpu_req.wdata[4:0];
        tcf_pkg::OFS_FIFO_CFG:
        begin
          next_st.cfg.cell_fifo_base = cpu_req.wdata[11:0];
          next_st.cfg.cell_fifo_size_code =
            cpu_req.wdata[tcf_pkg::SIZE_MSB:tcf_pkg::SIZE_LSB];
        end
        tcf_pkg::OFS_WR_INDEX:
          next_st.cfg.cell_fifo_wr_index = cpu_req.wdata[7:0];
        default:
          next_st.cfg = st.cfg;
      endcase
    end
    next_st.rdata = 16'h0000;
    if (cpu_req.cs && cpu_req.rd)
    begin
      case (cpu_req.addr)
        tcf_pkg::OFS_CS_BASE:
          next_st.rdata = {11'h000, st.cfg.ctrl_struct_addr_high};
        tcf_pkg::OFS_FIFO_CFG:
          next_st.rdata = {2'h0, st.cfg.cell_fifo_size_code,
                           st.cfg.cell_fifo_base};
        tcf_pkg::OFS_WR_INDEX:
          next_st.rdata = {8'h00, st.cfg.cell_fifo_wr_index};
        tcf_pkg::OFS_RD_INDEX:
          next_st.rdata = {9'h000, rd_index};
        default:
          next_st.rdata = 16'h0000;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st.cfg.ctrl_struct_addr_high <= tcf_pkg::RST_CS_BASE;
      st.cfg.cell_fifo_base <= tcf_pkg::RST_FIFO_BASE;
      st.cfg.cell_fifo_size_code <= tcf_pkg::RST_SIZE_CODE;
      st.cfg.cell_fifo_wr_index <= tcf_pkg::RST_WR_INDEX;
      st.rdata <= 16'h0000;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign cfg = st.cfg;
  assign cpu_rdata = st.rdata;

endmodule
`default_nettype wire

// ===== src/tcf_tx_cell_fifo_addr.sv
// transmit control-structure addressing and non-cbr cell fifo pointers
//
// Overview of operation
// - control structure address from base and entry
// - fifo base gives bits 20:9, low zero
// - each cell takes one 64-byte slot
// - size code selects 16/32/64/128 cells
// - cell at write index is never sent
// - write index reads zero above bit 7
// - read index shows cell being sent
// - unused base and read index bits zero
// - fifo config bits 15:14 read zero
`timescale 1ns/100ps
`default_nettype none
module tcf_tx_cell_fifo_addr (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // processor port
  input wire tcf_pkg::tcf_cpu_req_t cpu_req,
  output logic [15:0] cpu_rdata,
  // from transmit control register
  input wire logic cell_fifo_enable,
  // control-structure fetch from scheduler
  input wire logic cs_fetch,
  input wire logic [11:0] cs_entry,
  output logic cs_addr_valid,
  output logic [20:0] cs_addr,
  // cell drain toward the transmit segmenter
  output logic cell_valid,
  output logic [20:0] cell_addr,
  output logic [6:0] cell_fifo_rd_index,
  input wire logic cell_done,
  output logic cell_fifo_empty
);

  typedef struct packed {
    tcf_pkg::tcf_state_t fsm;
    logic [6:0] rd_index;
    logic [20:0] cell_addr;
    logic [20:0] cs_addr;
    logic cs_addr_valid;
  } tcf_main_st_t;

  tcf_main_st_t st;
  tcf_main_st_t next_st;
  tcf_pkg::tcf_cfg_t cfg;
  logic [6:0] size_mask;
  logic [6:0] wr_masked;
  logic [6:0] rd_masked;
  logic empty;
  logic avail;

  // ==========================================================
  // register file
  tcf_regs u_regs (
    .clk(clk),
    .rst_n(rst_n),
    .cpu_req(cpu_req),
    .cpu_rdata(cpu_rdata),
    .rd_index(st.rd_index),
    .cfg(cfg)
  );

  // ==========================================================
  // fifo occupancy
  always_comb
  begin
    size_mask = tcf_pkg::tcf_size_mask(cfg.cell_fifo_size_code);
    // wide write index folds onto the configured ring
    wr_masked = cfg.cell_fifo_wr_index[6:0] & size_mask;
    rd_masked = st.rd_index & size_mask;
    empty = (rd_masked == wr_masked);
    avail = cell_fifo_enable && !empty;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    next_st = st;
    next_st.cs_addr_valid = 1'b0;
    if (cs_fetch)
    begin
      // base on 20:16, entry on 15:4
      next_st.cs_addr = {cfg.ctrl_struct_addr_high, cs_entry, 4'h0};
      next_st.cs_addr_valid = 1'b1;
    end
    case (st.fsm)
      tcf_pkg::TCF_IDLE:
      begin
        if (avail)
        begin
          // slot n sits n*64 above base
          next_st.cell_addr =
            tcf_pkg::tcf_cell_addr(cfg.cell_fifo_base, rd_masked);
          next_st.fsm = tcf_pkg::TCF_SEND;
        end
      end
      tcf_pkg::TCF_SEND:
      begin
        if (cell_done)
        begin
          next_st.rd_index = (st.rd_index + 7'h01) & size_mask;
          next_st.fsm = tcf_pkg::TCF_IDLE;
        end
      end
      default:
        next_st.fsm = tcf_pkg::TCF_IDLE;
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st.fsm <= tcf_pkg::TCF_IDLE;
      st.rd_index <= tcf_pkg::RST_RD_INDEX;
      st.cell_addr <= 21'h000000;
      st.cs_addr <= 21'h000000;
      st.cs_addr_valid <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs
  // a cell in flight finishes even if enable drops meanwhile
  assign cell_valid = (st.fsm == tcf_pkg::TCF_SEND);
  assign cell_addr = st.cell_addr;
  assign cell_fifo_rd_index = st.rd_index;
  assign cell_fifo_empty = empty;
  assign cs_addr = st.cs_addr;
  assign cs_addr_valid = st.cs_addr_valid;

endmodule
`default_nettype wire

// ===== testbench/tcf_seg_model.sv
// segmenter model that sends each presented cell, prompt or slow
`timescale 1ns/100ps
`default_nettype none
module tcf_seg_model (
  // clock
  input wire logic clk,
  // cell handshake
  input wire logic cell_valid,
  output logic cell_done
);
  logic [1:0] cnt;
  logic slow;
  initial {cnt, slow, cell_done} = '0;
  // ==========================================
  // alternate zero and three wait cycles
  always @(posedge clk)
    if (!cell_valid || cell_done)
    begin
      cnt <= 2'h0;
      cell_done <= 1'b0;
    end
    else if (cnt == (slow ? 2'h3 : 2'h0))
    begin
      cell_done <= 1'b1;
      slow <= !slow;
    end
    else
      cnt <= cnt + 2'h1;
endmodule
`default_nettype wire

// ===== testbench/tcf_tx_cell_fifo_addr_bench.sv
// self-checking bench for the transmit cell fifo addressing block
`timescale 1ns/100ps
`default_nettype none
module tcf_tx_cell_fifo_addr_bench;
  logic clk, rst_n, en, cs_fetch, cell_done, cell_valid, cs_addr_valid;
  logic cell_fifo_empty;
  tcf_pkg::tcf_cpu_req_t req;
  logic [15:0] rdata;
  logic [11:0] cs_entry;
  logic [20:0] cs_addr, cell_addr;
  logic [6:0] rd_idx, exp_idx, mask, wr;
  int bad_count, checks_done, cyc;
  logic [47:0] rows [5];
  tcf_tx_cell_fifo_addr i_dut (.clk(clk), .rst_n(rst_n), .cpu_req(req),
    .cpu_rdata(rdata), .cell_fifo_enable(en), .cs_fetch(cs_fetch),
    .cs_entry(cs_entry), .cs_addr_valid(cs_addr_valid), .cs_addr(cs_addr),
    .cell_valid(cell_valid), .cell_addr(cell_addr),
    .cell_fifo_rd_index(rd_idx), .cell_done(cell_done),
    .cell_fifo_empty(cell_fifo_empty));
  tcf_seg_model i_seg (.clk(clk), .cell_valid(cell_valid),
    .cell_done(cell_done));
  initial
  begin
    clk = 0;
    forever #20 clk = !clk;
  end
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [15:0] a, d, x);
    @(posedge clk);
    req <= '{1'b1, w, !w, a, d};
    @(posedge clk);
    req <= '0;
    #1;
    if (!w) chk({5'h00, rdata}, {5'h00, x});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ==========================================
  // cell address of every sent cell
  always @(posedge clk)
    if (cell_valid && cell_done)
    begin
      chk(cell_addr, 21'h020000 + 21'(exp_idx) * 21'h40);
      exp_idx = (exp_idx + 7'h01) & mask;
    end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      bad_count++;
      conclude();
    end
  end
  // ==========================================
  // main sequence
  initial
  begin
    {rst_n, en, cs_fetch, cs_entry, req, exp_idx, wr} = '0;
    {bad_count, checks_done, cyc} = '0;
    mask = 7'h0F;
    rows = '{{16'h2040, 16'hFFFF, 16'h001F}, {16'h2050, 16'hFFFF, 16'h3FFF},
      {16'h2052, 16'hFFFF, 16'h00FF}, {16'h2054, 16'hFFFF, 16'h0000},
      {16'h2056, 16'hFFFF, 16'h0000}};
    repeat (20) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 4; i++)
      acc(0, rows[i][47:32], 0, 0);
    for (int i = 0; i < 5; i++)
    begin
      acc(1, rows[i][47:32], rows[i][31:16], 0);
      acc(0, rows[i][47:32], 0, rows[i][15:0]);
    end
    $display("register test done");
    // base set while no scheduler runs
    acc(1, 16'h2040, 16'h0015, 0);
    @(posedge clk);
    cs_fetch <= 1;
    cs_entry <= 12'hABC;
    @(posedge clk);
    cs_fetch <= 0;
    #1 chk(cs_addr, {5'h15, 12'hABC, 4'h0});
    chk(21'(cs_addr_valid), 21'h1);
    $display("fetch test done");
    for (int c = 0; c < 4; c++)
    begin
      // resize while off, fifo kept in one 8 KB region
      acc(1, 16'h2050, {2'h0, c[1:0], 12'h100}, 0);
      mask = 7'((16 << c) - 1);
      wr = (rd_idx - 7'h01) & mask;
      acc(1, 16'h2052, {9'h000, wr}, 0);
      repeat (4) @(posedge clk);
      chk(21'(cell_valid), 21'h0);
      en <= 1;
      for (int k = 0; k < 1200 && !(cell_fifo_empty && !cell_valid); k++)
        @(posedge clk);
      repeat (3) @(posedge clk);
      chk(21'(cell_valid), 21'h0);
      chk(21'(cell_fifo_empty), 21'h1);
      chk(21'(rd_idx), 21'(wr));
      chk(21'(exp_idx), 21'(wr));
      en <= 0;
      $display("size test done");
    end
    conclude();
  end
endmodule
`default_nettype wire

// ===== testbench/tcf_tx_cell_fifo_addr_monitor.sv
// port checker for the transmit cell fifo addressing block
`timescale 1ns/100ps
`default_nettype none
module tcf_check (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // processor port
  input wire tcf_pkg::tcf_cpu_req_t cpu_req,
  input wire logic [15:0] cpu_rdata,
  // fetch and drain
  input wire logic cell_fifo_enable,
  input wire logic cs_fetch,
  input wire logic [11:0] cs_entry,
  input wire logic cs_addr_valid,
  input wire logic [20:0] cs_addr,
  input wire logic cell_valid,
  input wire logic [20:0] cell_addr,
  input wire logic [6:0] cell_fifo_rd_index,
  input wire logic cell_done,
  input wire logic cell_fifo_empty
);
  // ==========================================
  // assertions
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_cs_addr_form: assert property (cs_fetch |=> cs_addr_valid &&
    cs_addr[15:4] == $past(cs_entry) && cs_addr[3:0] == 4'h0)
    else $error("bad control address");
  a_cs_valid_pulse: assert property (!cs_fetch |=> !cs_addr_valid)
    else $error("stray address valid");
  a_cell_slot: assert property (cell_valid |-> cell_addr[5:0] == 6'h00)
    else $error("cell not on a slot");
  a_no_idle_send: assert property (!cell_valid &&
    (!cell_fifo_enable || cell_fifo_empty) |=> !cell_valid)
    else $error("cell sent while idle");
  a_wr_not_sent: assert property (cell_valid |-> !cell_fifo_empty)
    else $error("write cell sent");
  a_cell_hold: assert property (cell_valid && !cell_done |=>
    cell_valid && $stable(cell_addr)) else $error("cell dropped");
  a_rd_advance: assert property (cell_valid && cell_done |=> !cell_valid
    && cell_fifo_rd_index != $past(cell_fifo_rd_index))
    else $error("read index stuck");
  a_rd_high_zero: assert property (cpu_req.cs && cpu_req.rd &&
    cpu_req.addr == tcf_pkg::OFS_RD_INDEX |=>
    cpu_rdata == {9'h000, $past(cell_fifo_rd_index)})
    else $error("bad read index readback");
  a_rdata_idle: assert property (!(cpu_req.cs && cpu_req.rd) |=>
    cpu_rdata == 16'h0000) else $error("read data not idle");
endmodule
bind tcf_tx_cell_fifo_addr tcf_check i_chk (.clk(clk), .rst_n(rst_n),
  .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
  .cell_fifo_enable(cell_fifo_enable), .cs_fetch(cs_fetch),
  .cs_entry(cs_entry), .cs_addr_valid(cs_addr_valid), .cs_addr(cs_addr),
  .cell_valid(cell_valid), .cell_addr(cell_addr),
  .cell_fifo_rd_index(cell_fifo_rd_index), .cell_done(cell_done),
  .cell_fifo_empty(cell_fifo_empty));
`default_nettype wire
